// ===== rtl/pll_lock_detect_and_cal_status.sv
// Register file and lock logic around an analog PLL.
// Assumes an Avalon-MM master on ref_clk_i and synchronous analog status.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module pll_lock_detect_and_cal_status
    import pll_lock_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    input  wire logic        precision_lock_i,
    input  wire logic        original_lock_i,
    input  wire logic        cal_done_i,
    input  wire logic        cal_fail_i,
    input  wire logic [5:0]  vco_band_i,
    output logic             third_pole_bypass_o,
    output logic      [2:0]  third_pole_resistor_code_o,
    output logic      [2:0]  third_pole_capacitor_code_o,
    output logic      [2:0]  lock_filter_res_o,
    output logic      [3:0]  precision_high_threshold_o,
    output logic      [3:0]  precision_low_threshold_o,
    output logic             precision_en_o,
    output logic             lock_pin_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    logic        third_pole_bypass_r;
    logic [2:0]  res3_r;
    logic [2:0]  cap3_r;
    logic        raw_to_pin_r;
    logic        prec_en_r;
    logic [1:0]  timer_r;
    logic        sticky_r;
    logic        cal_run_r;
    logic        det_bypass_r;
    logic [2:0]  filt_res_r;
    logic [3:0]  th_high_r;
    logic [3:0]  th_low_r;
    logic [IRQ_W-1:0] irq_sts_r;
    logic [IRQ_W-1:0] irq_mask_r;

    logic        req_r;
    logic        wr_acc;
    logic        rd_acc;
    logic        bank;
    logic [3:0]  ofs;
    logic        mapped;
    logic [31:0] rd_data;
    logic [7:0]  wd0;
    logic [7:0]  wd1;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: every access completes one cycle after it starts.

    assign bank   = avs_address_i[4];
    assign ofs    = {avs_address_i[3:2], 2'b00};
    assign wr_acc = avs_write_i && req_r;
    assign rd_acc = avs_read_i && req_r;
    assign wd0    = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
    assign wd1    = avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_r <= 1'b0;
        end else begin
            req_r <= (avs_read_i || avs_write_i) && !req_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !req_r);
        end
    end

    always_comb begin
        mapped = (avs_address_i[1:0] == 2'b00);
        if (bank == BANK_STS && ofs > OFS_IRQ_MASK) begin
            mapped = 1'b0;
        end
    end

    logic lock_db;
    logic sel_raw;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (bank == BANK_CFG) begin
            case (ofs)
                OFS_THIRD_POLE: rd_data[7:0] = {third_pole_bypass_r, res3_r,
                                                1'b0, cap3_r};
                OFS_LOCK_CFG:   rd_data[9:0] = {raw_to_pin_r, prec_en_r,
                                                timer_r, sticky_r, cal_run_r,
                                                det_bypass_r, filt_res_r};
                OFS_THRESH:     rd_data[7:0] = {th_high_r, th_low_r};
                OFS_CAL_STATUS: rd_data[7:0] = {cal_fail_i,
                                                cal_done_i,
                                                vco_band_i};
                default:        rd_data = 32'h0000_0000;
            endcase
        end else begin
            case (ofs)
                OFS_LOCK_STATUS: rd_data[1:0] = {sel_raw,
                                                 lock_db};
                OFS_IRQ_STATUS:  rd_data[IRQ_W-1:0] = irq_sts_r;
                OFS_IRQ_MASK:    rd_data[IRQ_W-1:0] = irq_mask_r;
                default:         rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_response_o <= 2'h0;
        end else if (avs_read_i || avs_write_i) begin
            avs_readdata_o <= rd_acc || !req_r ? rd_data : 32'h0000_0000;
            avs_response_o <= mapped ? 2'h0 : 2'h2;
        end
    end

    // Third pole and lock-filter configuration.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            third_pole_bypass_r <= 1'b0;
            res3_r              <= RST_RES3;
            cap3_r              <= RST_CAP3;
        end else if (wr_acc && mapped && bank == BANK_CFG
                     && ofs == OFS_THIRD_POLE && avs_byteenable_i[0]) begin
            // Software must only bypass with an integer feedback divider.
            third_pole_bypass_r <= wd0[BIT_BYPASS_P3];
            res3_r              <= wd0[POS_RES3 +: 3];
            cap3_r              <= wd0[POS_CAP3 +: 3];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            raw_to_pin_r <= 1'b0;
            prec_en_r    <= RST_PREC_EN;
            timer_r      <= RST_TIMER;
            sticky_r     <= 1'b0;
            cal_run_r    <= 1'b0;
            det_bypass_r <= 1'b0;
            filt_res_r   <= RST_FILT_RES;
        end else if (wr_acc && mapped && bank == BANK_CFG
                     && ofs == OFS_LOCK_CFG) begin
            if (avs_byteenable_i[0]) begin
                timer_r      <= wd0[POS_TIMER +: 2];
                sticky_r     <= wd0[BIT_STICKY];
                cal_run_r    <= wd0[BIT_CAL_RUN];
                det_bypass_r <= wd0[BIT_DET_BYPASS];
                filt_res_r   <= wd0[POS_FILT_RES +: 3];
            end
            if (avs_byteenable_i[1]) begin
                raw_to_pin_r <= wd1[BIT_RAW_TO_PIN - 8];
                prec_en_r    <= wd1[BIT_PREC_EN - 8];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            th_high_r <= RST_TH;
            th_low_r  <= RST_TH;
        end else if (wr_acc && mapped && bank == BANK_CFG
                     && ofs == OFS_THRESH && avs_byteenable_i[0]) begin
            th_high_r <= wd0[POS_TH_HIGH +: 4];
            th_low_r  <= wd0[POS_TH_LOW +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock selection and debounce.

    lock_ctl_if lk ();

    logic [16:0] interval;

    always_comb begin
        case (timer_r)
            2'h0:    interval = 17'h0;
            2'h1:    interval = DEB_CYC_1;
            2'h2:    interval = DEB_CYC_2;
            2'h3:    interval = DEB_CYC_3;
            default: interval = 17'h0;
        endcase
    end

    assign sel_raw       = prec_en_r ? precision_lock_i
                                     : original_lock_i;
    assign lk.raw_lock   = sel_raw;
    assign lk.interval   = interval;
    assign lk.sticky     = sticky_r;
    assign lk.det_bypass = det_bypass_r;
    assign lk.det_run    = cal_run_r || cal_done_i;
    assign lock_db       = lk.lock;

    lock_debounce u_debounce (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .ctl       (lk.core)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: lock gained, lock lost, calibration finished.

    logic             lock_q_r;
    logic             done_q_r;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_q_r <= 1'b0;
            done_q_r <= 1'b0;
        end else begin
            lock_q_r <= lock_db;
            done_q_r <= cal_done_i;
        end
    end

    assign ev[IRQ_LOCK_GAIN] = lock_db && !lock_q_r;
    assign ev[IRQ_LOCK_LOSS] = !lock_db && lock_q_r;
    assign ev[IRQ_CAL_DONE]  = cal_done_i && !done_q_r;
    assign clr = (wr_acc && mapped && bank == BANK_STS
                  && ofs == OFS_IRQ_STATUS) ? wd0[IRQ_W-1:0] : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= (irq_sts_r & ~clr) | ev;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_r <= '0;
        end else if (wr_acc && mapped && bank == BANK_STS
                     && ofs == OFS_IRQ_MASK && avs_byteenable_i[0]) begin
            irq_mask_r <= wd0[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs to the analog side and pins.

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            third_pole_bypass_o        <= 1'b0;
            third_pole_resistor_code_o <= RST_RES3;
            third_pole_capacitor_code_o <= RST_CAP3;
            lock_filter_res_o          <= RST_FILT_RES;
            precision_high_threshold_o <= RST_TH;
            precision_low_threshold_o  <= RST_TH;
            precision_en_o             <= RST_PREC_EN;
            lock_pin_o                 <= 1'b0;
            irq_o                      <= 1'b0;
        end else begin
            third_pole_bypass_o        <= third_pole_bypass_r;
            third_pole_resistor_code_o <= res3_r;
            third_pole_capacitor_code_o <= cap3_r;
            lock_filter_res_o          <= filt_res_r;
            precision_high_threshold_o <= th_high_r;
            precision_low_threshold_o  <= th_low_r;
            precision_en_o             <= prec_en_r;
            lock_pin_o                 <= raw_to_pin_r ? sel_raw
                                                       : lock_db;
            irq_o                      <= |(irq_sts_r & irq_mask_r);
        end
    end

endmodule

// ===== rtl/pll_lock_pkg.sv
// Constants for the PLL lock-detect and calibration status block.
// Assumes a 100 MHz system clock and an Avalon-MM register bus.
package pll_lock_pkg;

    // Register byte offsets.
    localparam logic [3:0] OFS_THIRD_POLE   = 4'h0;
    localparam logic [3:0] OFS_LOCK_CFG     = 4'h4;
    localparam logic [3:0] OFS_THRESH       = 4'h8;
    localparam logic [3:0] OFS_CAL_STATUS   = 4'hc;
    localparam logic [3:0] OFS_LOCK_STATUS  = 4'h0;
    localparam logic [3:0] OFS_IRQ_STATUS   = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK     = 4'h8;
    localparam logic       BANK_CFG         = 1'b0;
    localparam logic       BANK_STS         = 1'b1;

    // Third-pole register fields.
    localparam int BIT_BYPASS_P3   = 7;
    localparam int POS_RES3        = 4;
    localparam int POS_CAP3        = 0;
    localparam logic [2:0] RST_RES3 = 3'h3;
    localparam logic [2:0] RST_CAP3 = 3'h7;

    // Lock detector config fields.
    localparam int BIT_RAW_TO_PIN   = 9;
    localparam int BIT_PREC_EN      = 8;
    localparam int POS_TIMER        = 6;
    localparam int BIT_STICKY       = 5;
    localparam int BIT_CAL_RUN      = 4;
    localparam int BIT_DET_BYPASS   = 3;
    localparam int POS_FILT_RES     = 0;
    localparam logic       RST_PREC_EN  = 1'b1;
    localparam logic [1:0] RST_TIMER    = 2'h2;
    localparam logic [2:0] RST_FILT_RES = 3'h0;

    // Threshold fields.
    localparam int POS_TH_HIGH = 4;
    localparam int POS_TH_LOW  = 0;
    localparam logic [3:0] RST_TH = 4'h8;

    // Calibration status fields.
    localparam int BIT_CAL_FAIL = 7;
    localparam int BIT_CAL_DONE = 6;

    // Interrupt status bits.
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_CAL_DONE  = 2;
    localparam int IRQ_W         = 3;

    // Debounce intervals of 570, 5700 and 57000 system clock cycles.
    localparam logic [16:0] DEB_CYC_1 = 17'h0023a;
    localparam logic [16:0] DEB_CYC_2 = 17'h01644;
    localparam logic [16:0] DEB_CYC_3 = 17'h0dea8;

endpackage

// ===== rtl/lock_ctl_if.sv
// Interface carrying lock-detector controls to the debounce core.
// Assumes one clock domain shared by both modules.
`timescale 1ns/1ps
interface lock_ctl_if;
    logic        raw_lock;
    logic [16:0] interval;
    logic        sticky;
    logic        det_bypass;
    logic        det_run;
    logic        lock;

    modport ctl  (output raw_lock, interval, sticky, det_bypass, det_run,
                  input lock);
    modport core (input raw_lock, interval, sticky, det_bypass, det_run,
                  output lock);
endinterface

// ===== rtl/lock_debounce.sv
// Lock debounce with sticky lock and detector bypass.
// Assumes raw lock is synchronous to ref_clk_i.
`timescale 1ns/1ps
module lock_debounce
    import pll_lock_pkg::*;
(
    input  wire logic   ref_clk_i,
    input  wire logic   resetn_i,
    lock_ctl_if.core    ctl
);
    logic [16:0] count_r;
    logic        lock_r;
    logic        good;

    assign good = ctl.det_run && ctl.raw_lock;

    // Counts how long the raw lock has held; any drop restarts it.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_r <= '0;
        end else if (!good) begin
            count_r <= '0;
        end else if (count_r < ctl.interval) begin
            count_r <= count_r + 17'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_r <= 1'b0;
        end else if (ctl.det_bypass) begin
            lock_r <= 1'b1;
        end else if (good && count_r >= ctl.interval) begin
            lock_r <= 1'b1;
        end else if (!ctl.sticky || !ctl.det_run) begin
            lock_r <= 1'b0;
        end
    end

    assign ctl.lock = lock_r;
endmodule

// ===== verification/pll_core_model.sv
// Model of the analog PLL core, lock comparators and VCO calibration.
// Assumes bench commands arrive synchronous to ref_clk_i.
`timescale 1ns/1ps
module pll_core_model #(
    parameter int CAL_CYC = 200
) (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       cal_start_i,
    input  wire logic       cal_bad_i,
    input  wire logic [5:0] band_i,
    input  wire logic       prec_cmd_i,
    input  wire logic       orig_cmd_i,
    output logic            precision_lock_o,
    output logic            original_lock_o,
    output logic            cal_done_o,
    output logic            cal_fail_o,
    output logic      [5:0] vco_band_o
);
    logic [15:0] cnt_r;

    // Calibration runs after reset and again on command.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 16'h0;
        end else if (cal_start_i) begin
            cnt_r <= 16'h0;
        end else if (cnt_r != 16'(CAL_CYC)) begin
            cnt_r <= cnt_r + 16'h1;
        end
    end

    // Until calibration ends, fail and band are not valid and keep changing.
    assign cal_done_o = (cnt_r == 16'(CAL_CYC));
    assign cal_fail_o = cal_done_o ? cal_bad_i : cnt_r[0];
    assign vco_band_o = cal_done_o ? band_i : cnt_r[5:0];
    assign precision_lock_o = prec_cmd_i;
    assign original_lock_o = orig_cmd_i;
endmodule

// ===== verification/pll_lock_chk.sv
// Checker for the PLL lock and calibration status block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pll_lock_chk
    import pll_lock_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic        precision_lock_i,
    input wire logic        original_lock_i,
    input wire logic        cal_done_i,
    input wire logic [2:0]  third_pole_resistor_code_o,
    input wire logic [2:0]  third_pole_capacitor_code_o,
    input wire logic [3:0]  precision_high_threshold_o,
    input wire logic [3:0]  precision_low_threshold_o,
    input wire logic        lock_pin_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [9:0]  cfg_r;
    logic [2:0]  mask_r;
    logic [16:0] hi_cnt_r;
    logic        wr_acc;
    logic        sel_lock;
    logic        run;
    logic        dbn_ok;
    assign wr_acc = avs_write_i && !avs_waitrequest_o;
    assign sel_lock = cfg_r[BIT_PREC_EN] ? precision_lock_i : original_lock_i;
    assign run = cal_done_i || cfg_r[BIT_CAL_RUN];
    assign dbn_ok = !cfg_r[BIT_RAW_TO_PIN] && !cfg_r[BIT_DET_BYPASS]
                    && cfg_r[7:6] == 2'h1;
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of the lock config and mask, and a raw-lock run length.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_r <= 10'h180;
            mask_r <= 3'h0;
        end else if (wr_acc && avs_address_i == 5'h04) begin
            if (avs_byteenable_i[0]) cfg_r[7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1]) cfg_r[9:8] <= avs_writedata_i[9:8];
        end else if (wr_acc && avs_address_i == 5'h18) begin
            mask_r <= avs_writedata_i[2:0];
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hi_cnt_r <= 17'h0;
        end else if (!(sel_lock && run)) begin
            hi_cnt_r <= 17'h0;
        end else if (hi_cnt_r != 17'h1ffff) begin
            hi_cnt_r <= hi_cnt_r + 17'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_wait_one_cycle:
        assert property ($rose(avs_read_i || avs_write_i)
            |=> !avs_waitrequest_o)
        else $error("wait did not drop after one cycle");
    a_wait_pulse_single:
        assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low for more than one cycle");
    a_unmapped_error:
        assert property ((avs_read_i || avs_write_i) && !avs_waitrequest_o
            && (avs_address_i[1:0] != 2'h0 || avs_address_i == 5'h1c)
            |-> avs_response_o == 2'h2)
        else $error("unmapped access not refused");
    a_cfg_on_write:
        assert property (!$stable({third_pole_resistor_code_o,
            third_pole_capacitor_code_o, precision_high_threshold_o,
            precision_low_threshold_o}) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("config output changed without a write");
    a_debounce_early:
        assert property ($rose(lock_pin_o) && dbn_ok |-> hi_cnt_r >= 17'h23a)
        else $error("lock rose before the interval");
    a_debounce_done:
        assert property (dbn_ok && hi_cnt_r == 17'h258 |-> lock_pin_o)
        else $error("lock missing after the interval");
    a_sticky_lock_holds:
        assert property ((cfg_r[BIT_STICKY] && !cfg_r[BIT_RAW_TO_PIN] && run
            && lock_pin_o)[*2] |=> lock_pin_o)
        else $error("sticky lock dropped");
    a_bypass_forces:
        assert property ((cfg_r[BIT_DET_BYPASS] && !cfg_r[BIT_RAW_TO_PIN])[*4]
            |-> lock_pin_o)
        else $error("bypass did not force lock");
    a_raw_pin_route:
        assert property ((cfg_r[BIT_RAW_TO_PIN] && $stable(sel_lock)
            && $stable(cfg_r))[*3] |-> lock_pin_o == sel_lock)
        else $error("pin does not show raw selected lock");
    a_irq_masked_low:
        assert property ((mask_r == 3'h0)[*2] |-> !irq_o)
        else $error("interrupt high while fully masked");
endmodule

bind pll_lock_detect_and_cal_status pll_lock_chk u_chk (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .precision_lock_i(precision_lock_i), .original_lock_i(original_lock_i),
    .cal_done_i(cal_done_i),
    .third_pole_resistor_code_o(third_pole_resistor_code_o),
    .third_pole_capacitor_code_o(third_pole_capacitor_code_o),
    .precision_high_threshold_o(precision_high_threshold_o),
    .precision_low_threshold_o(precision_low_threshold_o),
    .lock_pin_o(lock_pin_o), .irq_o(irq_o)
);

// ===== verification/pll_lock_detect_and_cal_status_test.sv
// Self-checking bench for the PLL lock and calibration status block.
// Assumes the analog side is played by pll_core_model.
`timescale 1ns/1ps
module pll_lock_detect_and_cal_status_test;
    logic        ref_clk_i, resetn_i, avs_read_i, avs_write_i;
    logic [4:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd_q;
    logic [3:0]  avs_byteenable_i;
    logic [1:0]  avs_response_o, rd_r;
    logic        avs_waitrequest_o, precision_lock_i, original_lock_i;
    logic        cal_done_i, cal_fail_i, lock_pin_o, irq_o, bypass, prec_en;
    logic [5:0]  vco_band_i, band_sel;
    logic [2:0]  res3, cap3, filt;
    logic [3:0]  thh, thl;
    logic        cal_start, cal_bad, prec_cmd, orig_cmd;
    int          bad_count, total_checks, cyc;

    pll_lock_detect_and_cal_status u_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .precision_lock_i(precision_lock_i),
        .original_lock_i(original_lock_i), .cal_done_i(cal_done_i),
        .cal_fail_i(cal_fail_i), .vco_band_i(vco_band_i),
        .third_pole_bypass_o(bypass), .third_pole_resistor_code_o(res3),
        .third_pole_capacitor_code_o(cap3), .lock_filter_res_o(filt),
        .precision_high_threshold_o(thh), .precision_low_threshold_o(thl),
        .precision_en_o(prec_en), .lock_pin_o(lock_pin_o), .irq_o(irq_o)
    );
    pll_core_model u_pll (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cal_start_i(cal_start),
        .cal_bad_i(cal_bad), .band_i(band_sel), .prec_cmd_i(prec_cmd),
        .orig_cmd_i(orig_cmd), .precision_lock_o(precision_lock_i),
        .original_lock_o(original_lock_i), .cal_done_o(cal_done_i),
        .cal_fail_o(cal_fail_i), .vco_band_o(vco_band_i)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd_q = avs_readdata_o;
        rd_r = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        check(n, rd_q & m, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic pin(input logic e);
        check("lock_pin", 32'(lock_pin_o), 32'(e));
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        {resetn_i, avs_read_i, avs_write_i, cal_start, cal_bad} = 5'h0;
        {prec_cmd, orig_cmd, avs_address_i, cyc} = '0;
        {avs_writedata_i, bad_count, total_checks} = '0;
        avs_byteenable_i = 4'hf;
        band_sel = 6'h2a;
        tick(2);
        resetn_i <= 1'b1;
        rd(5'h00, '1, 32'h37, "third_pole");
        rd(5'h04, '1, 32'h180, "lock_cfg");
        rd(5'h08, '1, 32'h88, "thresh");
        check("outs", 32'({res3, cap3, filt, thh, thl, prec_en}),
              32'h1f111);
        rd(5'h0c, 32'h40, 32'h0, "cal_busy");
        rd(5'h1c, '1, 32'h0, "unmapped");
        check("resp", 32'(rd_r), 32'h2);
        $display("test reset_values done");
        wr_blk: begin
            bus(1'b1, 5'h00, 32'hff); // Divider in integer mode.
            rd(5'h00, '1, 32'hf7, "third_pole_wr");
            bus(1'b1, 5'h08, 32'h3c);
            bus(1'b1, 5'h04, 32'h145);
            tick(2);
            check("outs_wr", 32'({bypass, res3, cap3, filt, thh, thl,
                  prec_en}), 32'h7fa79);
            bus(1'b1, 5'h04, 32'hffff);
            rd(5'h04, '1, 32'h3ff, "lock_cfg_wr");
        end
        $display("test readback done");
        while (cal_done_i !== 1'b1) tick(1);
        rd(5'h0c, '1, 32'h6a, "cal_ok");
        rd(5'h14, 32'h4, 32'h4, "irq_cal");
        check("irq_masked", 32'(irq_o), 32'h0);
        bus(1'b1, 5'h18, 32'h4);
        tick(2);
        check("irq_on", 32'(irq_o), 32'h1);
        bus(1'b1, 5'h14, 32'h4);
        tick(2);
        check("irq_clr", 32'(irq_o), 32'h0);
        cal_bad <= 1'b1;
        band_sel <= 6'h15;
        bus(1'b1, 5'h04, 32'h100);
        cal_start <= 1'b1;
        prec_cmd <= 1'b1;
        tick(1);
        cal_start <= 1'b0;
        tick(10);
        pin(1'b0);
        bus(1'b1, 5'h04, 32'h110);
        tick(4);
        pin(1'b1);
        rd(5'h0c, 32'h40, 32'h0, "cal_rerun");
        while (cal_done_i !== 1'b1) tick(1);
        rd(5'h0c, '1, 32'hd5, "cal_bad");
        $display("test calibration done");
        prec_cmd <= 1'b0;
        bus(1'b1, 5'h04, 32'h140);
        tick(5);
        pin(1'b0);
        prec_cmd <= 1'b1;
        tick(300);
        prec_cmd <= 1'b0;
        tick(2);
        prec_cmd <= 1'b1;
        tick(560);
        pin(1'b0);
        tick(20);
        pin(1'b1);
        rd(5'h10, 32'h3, 32'h3, "lock_sts");
        prec_cmd <= 1'b0;
        tick(4);
        pin(1'b0);
        rd(5'h10, 32'h3, 32'h0, "unlock_sts");
        bus(1'b1, 5'h04, 32'h180);
        prec_cmd <= 1'b1;
        tick(5700);
        pin(1'b0);
        tick(4);
        pin(1'b1);
        prec_cmd <= 1'b0;
        bus(1'b1, 5'h04, 32'h160);
        prec_cmd <= 1'b1;
        tick(600);
        prec_cmd <= 1'b0;
        tick(4);
        pin(1'b1);
        $display("test debounce done");
        bus(1'b1, 5'h04, 32'h148);
        tick(4);
        pin(1'b1);
        orig_cmd <= 1'b1;
        bus(1'b1, 5'h04, 32'h340);
        tick(4);
        pin(1'b0);
        prec_cmd <= 1'b1;
        orig_cmd <= 1'b0;
        tick(4);
        pin(1'b1);
        bus(1'b1, 5'h04, 32'h240);
        tick(4);
        pin(1'b0);
        $display("test routing done");
        test_done();
    end
endmodule
